/* logic/fpu_ctl_params.svh */
/*
 Constants for the floating-point branch and latency control:
 address width, branch offset layout and execution cycle counts.
 Assumes it is included by the package and the design files.
*/
`ifndef FPU_CTL_PARAMS_SVH
`define FPU_CTL_PARAMS_SVH

// ==========================================================
// Widths
`define ADDR_W 64
`define OFFSET_W 16
`define OFFSET_SHIFT 2
`define CNT_W 7

// ==========================================================
// Execution cycles per instruction class
`define LAT_ONE 7'h01
`define LAT_EARLY 7'h02
`define LAT_LOAD 7'h01
`define LAT_ADD 7'h03
`define LAT_MUL_S 7'h05
`define LAT_MUL_D 7'h08
`define LAT_DIV_S 7'h1D
`define LAT_DIV_D 7'h3A
`define LAT_CVT 7'h05
`define LAT_CVT_DS 7'h02
`define LAT_CVT_SD 7'h01
// Extra clock when a dependent instruction waits for the bypass
`define LAT_DEP_BUMP 7'h01

`endif

/* logic/fpu_ctl_pkg.sv */
/*
 Types for the floating-point branch and latency control.
 Assumes the constants header is on the include path.
*/
`include "fpu_ctl_params.svh"

package fpu_ctl_pkg;

   // ==========================================================
   // Data formats, one-hot
   typedef enum logic [3:0] {
      FMT_S = 4'h1,
      FMT_D = 4'h2,
      FMT_W = 4'h4,
      FMT_L = 4'h8
   } fmt_t;

   // ==========================================================
   // Instruction classes seen in the execute stage, one-hot
   typedef enum logic [12:0] {
      OP_INT = 13'h0001,     // Integer instruction
      OP_LOAD = 13'h0002,    // coproc_load_word / coproc_load_double
      OP_STORE = 13'h0004,   // coproc_store_word / coproc_store_double
      OP_XFER = 13'h0008,    // Moves and control transfers
      OP_ADD = 13'h0010,     // Add and subtract
      OP_MUL = 13'h0020,     // Multiply
      OP_DIV = 13'h0040,     // Divide and square root
      OP_CVT_RND = 13'h0080, // Round/trunc/ceil/floor, to word or long
      OP_CVT_S = 13'h0100,   // Convert to single
      OP_CVT_D = 13'h0200,   // Convert to double
      OP_SIMPLE = 13'h0400,  // Absolute, move, negate
      OP_CMP = 13'h0800,     // Compare
      OP_BR = 13'h1000       // The four fp branches
   } op_t;

   // Instruction presented by the integer pipeline
   typedef struct packed {
      logic valid;
      op_t op;
      fmt_t fmt;
      fmt_t src_fmt;
      logic br_true;
      logic br_likely;
      logic dep_next;
      logic src_exc;
      logic early_done;
      logic [`OFFSET_W-1:0] offset;
      logic [`ADDR_W-1:0] slot_pc;
   } instr_t;

   // Branch resolution handed back to fetch
   typedef struct packed {
      logic redirect;
      logic taken;
      logic nullify;
      logic [`ADDR_W-1:0] target;
   } branch_res_t;

endpackage

/* logic/op_timer.sv */
/*
 Down counter that times one floating-point instruction.
 Assumes load is only raised when the counter is idle or ending.
*/
`timescale 1ns/1ps
`include "fpu_ctl_params.svh"

module op_timer #(
   parameter int CNT_W = `CNT_W
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic load,
   input wire logic [CNT_W-1:0] load_val,
   output logic ending,
   output logic nxt_busy
);

   // ==========================================================
   // Counter
   logic [CNT_W-1:0] count_ff; // Cycles still to hold
   logic [CNT_W-1:0] nxt_count; // Next value
   logic count_live; // Non-zero count

   assign count_live = (count_ff != '0);
   // A fresh load wins over the running count
   assign nxt_count = load ? load_val :
                      (count_live ? count_ff - 1'b1 : count_ff);
   assign nxt_busy = (nxt_count != '0);
   // Zero load ends at once; otherwise the last counted cycle
   assign ending = load ? (load_val == '0) : (count_ff == {{(CNT_W-1){1'b0}}, 1'b1});

   // Count register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         count_ff <= '0;
      end else begin
         count_ff <= nxt_count;
      end
   end

endmodule

/* logic/fpu_branch_and_latency_control.sv */
/*
 Floating-point branch resolution and execution timing control.
 Assumes the shared integer pipeline presents one instruction per
 clock, holds it while stall_ff is high, and flags dependencies.
*/
`timescale 1ns/1ps
`include "fpu_ctl_params.svh"

// Summary of operation
// - target is slot address plus shifted offset
// - true forms take on condition, false otherwise
// - likely forms nullify slot when not taken
// - loads one or two cycles, transfers one
// - load used in delay slot interlocks once
// - no execute bypass; dependent waits one clock
// - stores, transfers, integer keep normal forwarding
// - source exception ends multicycle after two
// - other exceptions reported only at completion
// - add/subtract three cycles, two when trivial
// - multiply five/eight, two when trivial
// - multiply ends at two when early; no overlap
// - divide/root 29/58, two when trivial
// - conversions five, two or one cycles
// - abs, move, negate, compare, branch: one
// - dependent multicycle result costs one more
// - any other delay is one pipeline_clock
// - one shared pipeline, no software sync
// - fp branches have one delay slot
// - compare drives condition for later branch
module fpu_branch_and_latency_control #(
   parameter int CNT_W = `CNT_W
) (
   input wire logic clock,
   input wire logic nrst,
   input wire fpu_ctl_pkg::instr_t instr,
   input wire logic cmp_result,
   input wire logic exc_found,
   output logic stall_ff,
   output logic done_ff,
   output logic exc_report_ff,
   output logic fp_cond_ff,
   output fpu_ctl_pkg::branch_res_t branch_ff
);
   import fpu_ctl_pkg::*;

   // ==========================================================
   // Latency functions

   // Execution cycles of one instruction
   function automatic logic [CNT_W-1:0] exec_cycles(op_t op, fmt_t fmt, fmt_t src,
                                                   logic early);
      logic [CNT_W-1:0] n;
      n = CNT_W'(`LAT_ONE);
      case (op)
         OP_LOAD: n = CNT_W'(`LAT_LOAD);
         OP_ADD: n = early ? CNT_W'(`LAT_EARLY) : CNT_W'(`LAT_ADD);
         // A source exception or trivial operands (early) shorten it
         OP_MUL: n = early ? CNT_W'(`LAT_EARLY) :
                     ((fmt == FMT_D) ? CNT_W'(`LAT_MUL_D) : CNT_W'(`LAT_MUL_S));
         OP_DIV: n = early ? CNT_W'(`LAT_EARLY) :
                     ((fmt == FMT_D) ? CNT_W'(`LAT_DIV_D) : CNT_W'(`LAT_DIV_S));
         OP_CVT_RND: n = early ? CNT_W'(`LAT_EARLY) : CNT_W'(`LAT_CVT);
         OP_CVT_S: n = early ? CNT_W'(`LAT_EARLY) :
                       ((src == FMT_D) ? CNT_W'(`LAT_CVT_DS) : CNT_W'(`LAT_CVT));
         // Single to double is already one cycle, nothing to shorten
         OP_CVT_D: n = (src == FMT_S) ? CNT_W'(`LAT_CVT_SD) :
                       (early ? CNT_W'(`LAT_EARLY) : CNT_W'(`LAT_CVT));
         OP_SIMPLE, OP_CMP, OP_BR: n = CNT_W'(`LAT_ONE);
         default: n = CNT_W'(`LAT_ONE);
      endcase
      return n;
   endfunction

   // Results that never bypass execute to execute
   function automatic logic no_bypass(op_t op);
      case (op)
         OP_LOAD, OP_ADD, OP_MUL, OP_DIV, OP_CVT_RND, OP_CVT_S, OP_CVT_D,
         OP_SIMPLE, OP_CMP: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // ==========================================================
   // Issue decode
   logic accept; // Instruction starts execute this clock
   logic early; // Source exception or trivial operands
   logic dep_wait; // Dependent must wait for the late bypass
   logic [CNT_W-1:0] cycles; // Execution cycles
   logic [CNT_W-1:0] hold; // Clocks the pipeline is held
   logic is_br; // Fp branch in execute
   logic cond_hit; // Branch condition met
   logic [`ADDR_W-1:0] off_ext; // Sign-extended byte offset
   logic [`ADDR_W-1:0] target; // Computed branch target
   logic ending; // Current instruction completes
   logic nxt_busy; // Pipeline held next clock
   logic exc_pend_ff; // Exception waiting for completion
   logic nxt_exc_pend; // Next pending flag

   // One instruction at a time, so multiply never overlaps add
   assign accept = instr.valid && !stall_ff;
   assign early = instr.src_exc || instr.early_done;
   assign dep_wait = instr.dep_next && no_bypass(instr.op);
   assign cycles = exec_cycles(instr.op, instr.fmt, instr.src_fmt, early);
   assign hold = cycles - CNT_W'(`LAT_ONE) + (dep_wait ? CNT_W'(`LAT_DEP_BUMP) : '0);
   assign is_br = accept && (instr.op == OP_BR);
   // Condition line came from an earlier compare
   assign cond_hit = instr.br_true ? fp_cond_ff : !fp_cond_ff;
   assign off_ext = {{(`ADDR_W-`OFFSET_W-`OFFSET_SHIFT){instr.offset[`OFFSET_W-1]}},
                     instr.offset, {`OFFSET_SHIFT{1'b0}}};
   assign target = instr.slot_pc + off_ext;

   // ==========================================================
   // Execution timer
   op_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .clock(clock),
      .nrst(nrst),
      .load(accept),
      .load_val(hold),
      .ending(ending),
      .nxt_busy(nxt_busy)
   );

   // Late exceptions are parked until the instruction finishes
   assign nxt_exc_pend = ending ? 1'b0 :
                         (exc_pend_ff || (accept && instr.src_exc) || exc_found);

   // ==========================================================
   // Pipeline hold, completion and exception report
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         stall_ff <= 1'b0;
         done_ff <= 1'b0;
         exc_report_ff <= 1'b0;
         exc_pend_ff <= 1'b0;
      end else begin
         // Single hold line serves both units
         stall_ff <= nxt_busy;
         done_ff <= ending;
         // Source exception ends after two, others at finish
         exc_report_ff <= ending &&
                          (exc_pend_ff || (accept && instr.src_exc) || exc_found);
         exc_pend_ff <= nxt_exc_pend;
      end
   end

   // Compare result becomes the branch condition
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         fp_cond_ff <= 1'b0;
      end else if (accept && instr.op == OP_CMP) begin
         fp_cond_ff <= cmp_result;
      end
   end

   // Branch resolution; fetch applies it after the slot instruction
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         branch_ff <= '0;
      end else begin
         branch_ff.redirect <= is_br;
         branch_ff.taken <= is_br && cond_hit;
         branch_ff.nullify <= is_br && instr.br_likely && !cond_hit;
         if (is_br) begin
            branch_ff.target <= target;
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   // Issue qualifiers used by several checks
   logic iss_plain; // Accepted, no dependency, no early finish
   assign iss_plain = accept && !instr.dep_next && !early;

   sequence held_once_s;
      stall_ff ##1 !stall_ff;
   endsequence

   sequence mul_d_s;
      stall_ff [*7] ##1 !stall_ff;
   endsequence

   target_calc_a: assert property (
      is_br |=> branch_ff.target == $past(instr.slot_pc) +
         {{46{$past(instr.offset[15])}}, $past(instr.offset), 2'b00})
      else $error("branch target wrong");

   branch_sense_a: assert property (
      (is_br && (instr.br_true == fp_cond_ff)) |=> branch_ff.taken && branch_ff.redirect)
      else $error("branch sense wrong");

   likely_null_a: assert property (
      is_br |=> branch_ff.nullify == ($past(instr.br_likely) && !branch_ff.taken))
      else $error("slot nullify wrong");

   load_interlock_a: assert property (
      (accept && instr.op == OP_LOAD && instr.dep_next) |=> held_once_s)
      else $error("load interlock not one cycle");

   store_fwd_a: assert property (
      (accept && (instr.op == OP_STORE || instr.op == OP_XFER || instr.op == OP_INT))
      |=> !stall_ff ##0 done_ff)
      else $error("store or transfer stalled");

   cmp_dep_a: assert property (
      (accept && instr.op == OP_CMP && instr.dep_next) |=> held_once_s ##0 done_ff)
      else $error("compare dependent wait wrong");

   src_exc_a: assert property (
      (accept && instr.src_exc && !instr.dep_next && instr.op == OP_DIV)
      |-> ##2 (exc_report_ff && done_ff))
      else $error("source exception not at two");

   exc_end_a: assert property (
      exc_report_ff |-> done_ff)
      else $error("exception reported before completion");

   add_three_a: assert property (
      (iss_plain && instr.op == OP_ADD) |=> stall_ff ##1 stall_ff ##1 (!stall_ff && done_ff))
      else $error("add not three cycles");

   mul_double_a: assert property (
      (iss_plain && instr.op == OP_MUL && instr.fmt == FMT_D) |=> mul_d_s)
      else $error("double multiply not eight cycles");

   div_single_a: assert property (
      (iss_plain && instr.op == OP_DIV && instr.fmt == FMT_S) |-> ##29 done_ff)
      else $error("single divide not 29 cycles");

   cvt_ds_a: assert property (
      (iss_plain && instr.op == OP_CVT_S && instr.src_fmt == FMT_D)
      |=> stall_ff ##1 (!stall_ff && done_ff))
      else $error("double to single not two cycles");

   one_cycle_a: assert property (
      (accept && !instr.dep_next && (instr.op == OP_SIMPLE || instr.op == OP_BR))
      |=> done_ff && !stall_ff)
      else $error("single-cycle op held");

   mul_dep_a: assert property (
      (accept && instr.dep_next && !early && instr.op == OP_MUL && instr.fmt == FMT_S)
      |=> stall_ff [*5] ##1 !stall_ff)
      else $error("dependent multiply latency wrong");

   cmp_cond_a: assert property (
      (accept && instr.op == OP_CMP) |=> fp_cond_ff == $past(cmp_result))
      else $error("condition line not updated");

   // ==========================================================
   // Further checks on branches, the condition line and latencies

   // Finished in this cycle with the hold already dropped
   sequence done_now_s;
      !stall_ff && done_ff;
   endsequence

   // One held cycle, then completion
   sequence done_second_s;
      stall_ff ##1 done_now_s;
   endsequence

   // Four held cycles, then completion: five in all
   sequence held_four_s;
      stall_ff [*4] ##1 done_now_s;
   endsequence

   branch_miss_a: assert property (
      (is_br && (instr.br_true != fp_cond_ff)) |=> !branch_ff.taken && branch_ff.redirect)
      else $error("branch taken on wrong sense");

   likely_taken_a: assert property (
      (is_br && instr.br_likely && (instr.br_true == fp_cond_ff)) |=> !branch_ff.nullify)
      else $error("taken likely branch dropped its slot");

   // Branch resolves in one clock, so only the slot follows it
   slot_delay_a: assert property (
      is_br |=> done_now_s ##0 branch_ff.redirect)
      else $error("branch delay slot not one cycle");

   // Fetch relies on the target holding between branches
   target_hold_a: assert property (
      !is_br |=> $stable(branch_ff.target))
      else $error("branch target moved without a branch");

   cond_hold_a: assert property (
      !(accept && instr.op == OP_CMP) |=> $stable(fp_cond_ff))
      else $error("condition line moved without a compare");

   load_fast_a: assert property (
      (accept && instr.op == OP_LOAD && !instr.dep_next) |=> done_now_s)
      else $error("load without user held");

   early_end_a: assert property (
      (accept && early && !instr.dep_next &&
       (instr.op inside {OP_ADD, OP_MUL, OP_DIV, OP_CVT_RND, OP_CVT_S}))
      |=> done_second_s)
      else $error("early finish not at two cycles");

   mul_single_a: assert property (
      (iss_plain && instr.op == OP_MUL && instr.fmt != FMT_D) |=> held_four_s)
      else $error("single multiply not five cycles");

   div_double_a: assert property (
      (iss_plain && instr.op == OP_DIV && instr.fmt == FMT_D) |-> ##58 done_ff)
      else $error("double divide not 58 cycles");

   cvt_round_a: assert property (
      (iss_plain && instr.op == OP_CVT_RND) |=> held_four_s)
      else $error("round or convert not five cycles");

   cvt_sd_a: assert property (
      (accept && !instr.dep_next && instr.op == OP_CVT_D && instr.src_fmt == FMT_S)
      |=> done_now_s)
      else $error("single to double held");

   add_dep_a: assert property (
      (accept && instr.dep_next && !early && instr.op == OP_ADD)
      |=> stall_ff [*3] ##1 done_now_s)
      else $error("dependent add latency wrong");

   // One unit of work at a time: completion never overlaps a hold
   done_idle_a: assert property (
      done_ff |-> !stall_ff)
      else $error("completion while still held");

endmodule

/* testbench/int_pipe_model.sv */
/*
 Model of the shared integer pipeline that issues instructions.
 Assumes the bench queues work through push and that the control
 block holds an instruction while its stall output is high.
*/
`timescale 1ns/1ps

module int_pipe_model (
   input wire logic clock,
   input wire logic nrst,
   input wire logic stall_ff,
   output fpu_ctl_pkg::instr_t instr,
   output logic cmp_result
);
   import fpu_ctl_pkg::*;

   // ==========================================================
   // Pending instructions and their compare outcomes
   instr_t iq[$]; // Instructions waiting to issue
   logic cq[$]; // Compare outcome sent with each one

   // Queue one instruction for issue
   task automatic push(input instr_t i, input logic c);
      iq.push_back(i);
      cq.push_back(c);
   endtask

   // ==========================================================
   // Issue: advance only when idle or the current one is taken
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         instr <= '0;
         cmp_result <= 1'b0;
      end else if (!instr.valid || !stall_ff) begin
         if (iq.size() > 0) begin
            instr <= iq.pop_front();
            cmp_result <= cq.pop_front();
         end else begin
            // Idle: invert fields so stale values never look valid
            instr <= {1'b0, ~instr[$bits(instr_t)-2:0]};
            cmp_result <= ~cmp_result;
         end
      end
   end
endmodule

/* testbench/tb_fpu_branch_and_latency_control.sv */
/*
 Self-checking bench for the fp branch and latency control.
 Assumes the package is compiled first; the issuing pipeline is
 the partner model, and expectations come from the timing rules.
*/
`timescale 1ns/1ps

module tb_fpu_branch_and_latency_control;
   import fpu_ctl_pkg::*;

   // ==========================================================
   // Signals
   logic clock = 1'b0; // 20 MHz pipeline clock
   logic nrst = 1'b0; // Active-low reset
   logic exc_found = 1'b0; // Late arithmetic exception
   instr_t instr;
   logic cmp_result, stall_ff, done_ff, exc_report_ff, fp_cond_ff;
   branch_res_t branch_ff;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0; // Cycle count since reset release
   int exp_lat[$]; // Expected cycles from accept to done
   logic exp_exc[$]; // Expected exception flag at done
   logic [66:0] exp_br[$]; // Expected condition, taken, nullify, target
   int acc_q[$]; // Accept cycle of each instruction in flight
   logic cond_m = 1'b0; // Condition line as the bench expects it
   op_t ops[13] = '{OP_INT, OP_LOAD, OP_STORE, OP_XFER, OP_ADD, OP_MUL, OP_DIV,
      OP_CVT_RND, OP_CVT_S, OP_CVT_D, OP_SIMPLE, OP_CMP, OP_BR};
   fmt_t fmts[4] = '{FMT_S, FMT_D, FMT_W, FMT_L};

   // ==========================================================
   // Clock and instances
   initial begin
      forever #25 clock = ~clock;
   end

   fpu_branch_and_latency_control dut_u (.clock(clock), .nrst(nrst), .instr(instr),
      .cmp_result(cmp_result), .exc_found(exc_found), .stall_ff(stall_ff),
      .done_ff(done_ff), .exc_report_ff(exc_report_ff), .fp_cond_ff(fp_cond_ff),
      .branch_ff(branch_ff));

   int_pipe_model pipe_u (.clock(clock), .nrst(nrst), .stall_ff(stall_ff),
      .instr(instr), .cmp_result(cmp_result));

   // ==========================================================
   // Compare tasks, one per kind of result
   task automatic check_lat(input int e, input int g);
      n_tests++;
      if (e != g) begin
         error_cnt++;
         $display("mismatch latency expected %0d seen %0d", e, g);
      end
   endtask

   task automatic check_exc(input logic e, input logic g);
      n_tests++;
      if (e !== g) begin
         error_cnt++;
         $display("mismatch exception expected %b seen %b", e, g);
      end
   endtask

   task automatic check_vec(input string n, input logic [66:0] e, input logic [66:0] g);
      n_tests++;
      if (e !== g) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   // ==========================================================
   // Expected cycles: execution count plus one for a waiting user
   function automatic int lat(input instr_t i);
      logic e;
      int n;
      e = i.src_exc | i.early_done;
      case (i.op)
         OP_ADD: n = e ? 2 : 3;
         OP_MUL: n = e ? 2 : ((i.fmt == FMT_D) ? 8 : 5);
         OP_DIV: n = e ? 2 : ((i.fmt == FMT_D) ? 58 : 29);
         OP_CVT_RND: n = e ? 2 : 5;
         OP_CVT_S: n = (i.src_fmt == FMT_D) ? 2 : (e ? 2 : 5);
         OP_CVT_D: n = (i.src_fmt == FMT_S) ? 1 : (e ? 2 : 5);
         default: n = 1;
      endcase
      if (i.dep_next && !(i.op inside {OP_INT, OP_STORE, OP_XFER, OP_BR})) begin
         n++;
      end
      return n;
   endfunction

   // Build an instruction; x holds dep, source exception, early
   function automatic instr_t mk(input op_t o, input fmt_t f, input fmt_t s,
      input logic [2:0] x);
      instr_t i;
      i.valid = 1'b1;
      i.op = o;
      i.fmt = f;
      i.src_fmt = s;
      {i.dep_next, i.src_exc, i.early_done} = x;
      {i.br_true, i.br_likely} = 2'($urandom);
      i.offset = 16'($urandom);
      i.slot_pc = {$urandom, $urandom};
      return i;
   endfunction

   // Note the expected results, then hand the instruction over
   task automatic issue(input instr_t i, input logic c, input logic late);
      logic tk;
      exp_lat.push_back(lat(i));
      exp_exc.push_back(i.src_exc | late);
      if (i.op == OP_BR) begin
         tk = i.br_true ? cond_m : !cond_m;
         exp_br.push_back({cond_m, tk, i.br_likely & !tk,
            i.slot_pc + {{46{i.offset[15]}}, i.offset, 2'b00}});
      end
      if (i.op == OP_CMP) begin
         cond_m = c;
      end
      pipe_u.push(i, c);
   endtask

   // Wait, bounded, until every noted result has been seen
   task automatic drain;
      int k;
      for (k = 0; k < 3000 && exp_lat.size() > 0; k++) begin
         @(posedge clock);
      end
   endtask

   // ==========================================================
   // Monitor: completion first, then a new accept at the same edge
   always @(posedge clock) begin
      if (nrst) begin
         cyc++;
         if (done_ff === 1'b1 && exp_lat.size() > 0) begin
            check_lat(exp_lat.pop_front(), cyc - acc_q.pop_front());
            check_exc(exp_exc.pop_front(), exc_report_ff);
         end
         if (branch_ff.redirect === 1'b1 && exp_br.size() > 0) begin
            check_vec("branch", exp_br.pop_front(),
               {fp_cond_ff, branch_ff.taken, branch_ff.nullify, branch_ff.target});
         end
         if (instr.valid === 1'b1 && stall_ff === 1'b0) begin
            acc_q.push_back(cyc);
         end
      end
   end

   // ==========================================================
   // Verdict, reached from the main sequence or the watchdog
   task automatic stop_test;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Watchdog: far beyond the longest expected run
   initial begin
      #(50 * 30000);
      error_cnt++;
      stop_test();
   end

   // ==========================================================
   // Main sequence
   initial begin
      instr_t i;
      op_t o;
      void'($urandom(5261));
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      // Every class at full length, then the early finish
      foreach (ops[k]) begin
         issue(mk(ops[k], FMT_S, FMT_D, 3'b000), 1'b0, 1'b0);
      end
      issue(mk(OP_MUL, FMT_D, FMT_S, 3'b000), 1'b0, 1'b0);
      issue(mk(OP_DIV, FMT_D, FMT_S, 3'b000), 1'b0, 1'b0);
      foreach (fmts[k]) begin
         issue(mk(OP_CVT_S, FMT_S, fmts[k], 3'b000), 1'b0, 1'b0);
         issue(mk(OP_CVT_D, FMT_D, fmts[k], 3'b001), 1'b0, 1'b0);
      end
      foreach (ops[k]) begin
         issue(mk(ops[k], FMT_D, FMT_W, 3'b001), 1'b0, 1'b0);
         issue(mk(ops[k], FMT_S, FMT_L, 3'b100), 1'b0, 1'b0);
      end
      // Source exception cuts a long divide to two cycles
      issue(mk(OP_DIV, FMT_D, FMT_S, 3'b010), 1'b0, 1'b0);
      drain();
      // Late exception inside a multiply shows only at completion
      issue(mk(OP_MUL, FMT_D, FMT_S, 3'b000), 1'b0, 1'b1);
      repeat (4) @(posedge clock);
      exc_found <= 1'b1;
      @(posedge clock);
      exc_found <= 1'b0;
      drain();
      // All four branch forms against both condition values
      for (int k = 0; k < 8; k++) begin
         issue(mk(OP_CMP, FMT_S, FMT_S, 3'b000), k[0], 1'b0);
         i = mk(OP_BR, FMT_S, FMT_S, 3'b000);
         {i.br_likely, i.br_true} = k[2:1];
         issue(i, 1'b0, 1'b0);
      end
      // Random stream; source exceptions only on multicycle math
      for (int k = 0; k < 60; k++) begin
         o = ops[$urandom % 13];
         i = mk(o, ($urandom % 2) ? FMT_D : FMT_S, fmts[$urandom % 4], 3'($urandom));
         i.src_exc &= (o inside {OP_ADD, OP_MUL, OP_DIV, OP_CVT_RND});
         issue(i, 1'($urandom), 1'b0);
      end
      drain();
      repeat (3) @(posedge clock);
      check_lat(0, exp_lat.size() + exp_br.size());
      stop_test();
   end
endmodule
